//--- rtl/pcs_socket_strobes.sv
// Socket-side strobe, address and status logic of a PC Card socket controller
`include "pcs_map.svh"

// Function
// - Memory mode: REG picks attribute (low) or common (high) memory per access.
// - I/O mode, non-DMA: REG held low during I/O cycles.
// - DMA cycles: REG stays high throughout the I/O strobes.
// - ATA mode: REG permanently high.
// - A 26-bit card address is presented for every access.
// - 16-bit two-way data bus, driven on writes, sampled on reads.
// - Non-DMA memory read asserts OE low.
// - DMA write with IORD low: OE low whenever terminal count is high.
// - DMA read with IOWR low: OE stays high.
// - Non-DMA memory write asserts WE low.
// - DMA read with IOWR low: WE low whenever terminal count is high.
// - DMA write with IORD low: WE stays high.
// - IORD low for the duration of each I/O read.
// - IOWR low for the duration of each I/O write.
// - Card-type bit zero: shared input is the write-protect switch status.
// - I/O mode: low shared input means 16-bit I/O; size access accordingly.
// - DMA mode: software picks the shared input or INPACK as DMA request.
// - Memory mode: ready/busy input is readable as a status bit.
// - I/O mode: ready input is an active-low interrupt request.
// - Card WAIT low extends the cycle until WAIT returns high.
// - Low enable for even bytes, high for odd; 8-bit cards low enable, A0 set.
// - Card reset output floats unless card seated and interface enabled.
module pcs_socket_strobes
	import pcs_pkg::*;
#(
	parameter int FIFO_DEPTH = `PCS_FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic                I_CLK,
	input  wire logic                I_ARST_N,
	// Request stream
	input  wire logic                I_REQ_VALID,
	output logic                     O_REQ_READY,
	input  wire logic                I_REQ_WRITE,
	input  wire logic                I_REQ_IO,
	input  wire logic                I_REQ_ATTR,
	input  wire logic                I_REQ_DMA,
	input  wire logic                I_REQ_WIDE,
	input  wire logic [`PCS_AW-1:0]  I_REQ_ADDR,
	input  wire logic [`PCS_DW-1:0]  I_REQ_WDATA,
	// Completion
	output logic                     O_RSP_VALID,
	output logic [`PCS_DW-1:0]       O_RSP_DATA,
	output logic                     O_BUSY,
	// Configuration
	input  wire logic                I_IO_CARD,
	input  wire logic                I_ATA_MODE,
	input  wire logic                I_DMA_MODE,
	input  wire logic                I_DREQ_SEL_INPACK,
	input  wire logic                I_BUS8,
	input  wire logic                I_IF_ENABLE,
	input  wire logic                I_CARD_RESET,
	// Status
	output logic                     O_WRITE_PROTECT,
	output logic                     O_IO16,
	output logic                     O_READY,
	output logic                     O_CARD_IRQ,
	output logic                     O_DMA_REQ,
	output logic                     O_INPACK_SEEN,
	output logic                     O_CARD_SEATED,
	// Socket pins
	output logic [`PCS_AW-1:0]       O_CA,
	output logic [`PCS_DW-1:0]       O_CD_OUT,
	output logic                     O_CD_OE_N,
	input  wire logic [`PCS_DW-1:0]  I_CD_IN,
	output logic                     O_REG_N,
	output logic                     O_OE_N,
	output logic                     O_WE_N,
	output logic                     O_IORD_N,
	output logic                     O_IOWR_N,
	output logic                     O_CE1_N,
	output logic                     O_CE2_N,
	output logic                     O_CRESET,
	output logic                     O_CRESET_OE_N,
	input  wire logic                I_WP_IO16_N,
	input  wire logic                I_INPACK_N,
	input  wire logic                I_RDY_IREQ_N,
	input  wire logic                I_WAIT_N,
	input  wire logic                I_TC,
	input  wire logic [1:0]          I_CDET_N
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		pcs_state_type        st;
		logic [`PCS_CNT_W-1:0] cnt;
		pcs_req_type          req;
		logic                 split;
		logic                 hi;
		logic [`PCS_SY_W-1:0] s1;
		logic [`PCS_SY_W-1:0] s2;
		logic [`PCS_DW-1:0]   d1;
		logic [`PCS_DW-1:0]   d2;
		logic [`PCS_AW-1:0]   ca;
		logic [`PCS_DW-1:0]   dout;
		logic                 dout_oe_n;
		logic                 reg_n;
		logic                 oe_n;
		logic                 we_n;
		logic                 iord_n;
		logic                 iowr_n;
		logic                 ce1_n;
		logic                 ce2_n;
		logic [`PCS_DW-1:0]   rdata;
		logic                 rsp_valid;
		logic                 inpack_seen;
		logic                 creset;
		logic                 creset_oe_n;
	} pcs_core_type;

	pcs_core_type core_reg;
	pcs_core_type core_next;
	logic [1:0]   rst_sync;
	logic         rst_n;
	logic         fifo_valid;
	logic         fifo_pop;
	pcs_req_type  fifo_data;
	pcs_req_type  fifo_in;
	logic         tc;
	logic         wait_low;
	logic         seated;

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// ----------------------------------------------------------------
	// Request buffer
	// ----------------------------------------------------------------
	assign fifo_in = '{write: I_REQ_WRITE, io: I_REQ_IO, attr: I_REQ_ATTR, dma: I_REQ_DMA,
		wide: I_REQ_WIDE, addr: I_REQ_ADDR, wdata: I_REQ_WDATA};

	pcs_fifo #(
		.W     ($bits(pcs_req_type)),
		.DEPTH (FIFO_DEPTH)
	) u_req_fifo (
		.i_clk       (I_CLK),
		.i_rst_n     (rst_n),
		.i_in_valid  (I_REQ_VALID),
		.o_in_ready  (O_REQ_READY),
		.i_in_data   (fifo_in),
		.o_out_valid (fifo_valid),
		.i_out_ready (fifo_pop),
		.o_out_data  (fifo_data)
	);

	// ----------------------------------------------------------------
	// Decoding helpers
	// ----------------------------------------------------------------
	// Returns {ce2_n, ce1_n}
	function automatic logic [1:0] lanes(input logic wide, input logic a0, input logic bus8);
		if (bus8) begin
			lanes = 2'h2;
		end else if (wide) begin
			lanes = 2'h0;
		end else begin
			lanes = a0 ? 2'h1 : 2'h2;
		end
	endfunction : lanes

	function automatic logic reg_level(input pcs_req_type r, input logic ata);
		if (ata) begin
			reg_level = 1'b1;
		end else if (r.io) begin
			reg_level = r.dma;
		end else begin
			reg_level = !r.attr;
		end
	endfunction : reg_level

	// ----------------------------------------------------------------
	// Pin status
	// ----------------------------------------------------------------
	assign tc       = core_reg.s2[`PCS_SY_TC];
	assign wait_low = !core_reg.s2[`PCS_SY_WAIT];
	assign seated   = !core_reg.s2[`PCS_SY_CD1] && !core_reg.s2[`PCS_SY_CD2];

	assign O_WRITE_PROTECT = !I_IO_CARD && core_reg.s2[`PCS_SY_WP];
	assign O_IO16          = I_IO_CARD && !core_reg.s2[`PCS_SY_WP];
	assign O_READY         = !I_IO_CARD && core_reg.s2[`PCS_SY_RDY];
	assign O_CARD_IRQ      = I_IO_CARD && !core_reg.s2[`PCS_SY_RDY];
	assign O_DMA_REQ       = I_DMA_MODE && !(I_DREQ_SEL_INPACK ?
		core_reg.s2[`PCS_SY_INPACK] : core_reg.s2[`PCS_SY_WP]);
	assign O_CARD_SEATED   = seated;

	// ----------------------------------------------------------------
	// Cycle sequencer
	// ----------------------------------------------------------------
	always_comb begin
		core_next = core_reg;
		fifo_pop = 1'b0;
		core_next.rsp_valid = 1'b0;
		core_next.s1 = {I_CDET_N[1], I_CDET_N[0], I_TC, I_WAIT_N, I_RDY_IREQ_N, I_INPACK_N, I_WP_IO16_N};
		core_next.s2 = core_reg.s1;
		core_next.d1 = I_CD_IN;
		core_next.d2 = core_reg.d1;
		core_next.creset = I_CARD_RESET;
		core_next.creset_oe_n = !(seated && I_IF_ENABLE);
		case (core_reg.st)
			ST_IDLE: begin
				if (fifo_valid) begin
					fifo_pop = 1'b1;
					core_next.req = fifo_data;
					core_next.hi = 1'b0;
					core_next.split = 1'b0;
					core_next.ca = fifo_data.addr;
					if (fifo_data.wide && !I_BUS8) begin
						core_next.ca[0] = 1'b0;
					end
					{core_next.ce2_n, core_next.ce1_n} = lanes(fifo_data.wide, fifo_data.addr[0], I_BUS8);
					core_next.reg_n = reg_level(fifo_data, I_ATA_MODE);
					core_next.dout = fifo_data.wdata;
					if (!fifo_data.wide && !I_BUS8 && fifo_data.addr[0]) begin
						core_next.dout[`PCS_DW-1:`PCS_BYTE] = fifo_data.wdata[`PCS_BYTE-1:0];
					end
					core_next.dout_oe_n = !fifo_data.write;
					core_next.cnt = `PCS_CNT_W'(`PCS_SETUP_CYC - 1);
					core_next.st = ST_SETUP;
				end
			end
			ST_SETUP: begin
				if (core_reg.cnt != '0) begin
					core_next.cnt = core_reg.cnt - `PCS_CNT_W'(1);
				end else begin
					// IOIS16 read here from s2 was sampled at the edge that put the address out, before the card decodes it
					if (core_reg.req.io && !core_reg.req.dma && core_reg.req.wide && !core_reg.hi
						&& core_reg.s2[`PCS_SY_WP]) begin
						core_next.split = 1'b1;
						core_next.ce2_n = 1'b1;
					end
					if (core_reg.req.io || core_reg.req.dma) begin
						core_next.iord_n = core_reg.req.write;
						core_next.iowr_n = !core_reg.req.write;
						core_next.oe_n = !(core_reg.req.dma && !core_reg.req.write && tc);
						core_next.we_n = !(core_reg.req.dma && core_reg.req.write && tc);
					end else begin
						core_next.oe_n = core_reg.req.write;
						core_next.we_n = !core_reg.req.write;
					end
					core_next.cnt = `PCS_CNT_W'(`PCS_STROBE_CYC - 1);
					core_next.st = ST_STROBE;
				end
			end
			ST_STROBE: begin
				// Terminal count follows the pin for the whole DMA strobe
				if (core_reg.req.dma) begin
					core_next.oe_n = !(!core_reg.req.write && tc);
					core_next.we_n = !(core_reg.req.write && tc);
				end
				if (core_reg.cnt != '0) begin
					core_next.cnt = core_reg.cnt - `PCS_CNT_W'(1);
				end else if (!wait_low) begin
					// Bus copy lags two cycles; strobe is long enough to cover it
					if (!core_reg.req.write) begin
						if (core_reg.hi) begin
							core_next.rdata[`PCS_DW-1:`PCS_BYTE] = core_reg.d2[`PCS_BYTE-1:0];
						end else if (core_reg.ce1_n) begin
							core_next.rdata = {{`PCS_BYTE{1'b0}}, core_reg.d2[`PCS_DW-1:`PCS_BYTE]};
						end else if (core_reg.ce2_n) begin
							core_next.rdata = {{`PCS_BYTE{1'b0}}, core_reg.d2[`PCS_BYTE-1:0]};
						end else begin
							core_next.rdata = core_reg.d2;
						end
					end
					if (!core_reg.iord_n) begin
						core_next.inpack_seen = !core_reg.s2[`PCS_SY_INPACK];
					end
					core_next.oe_n = 1'b1;
					core_next.we_n = 1'b1;
					core_next.iord_n = 1'b1;
					core_next.iowr_n = 1'b1;
					core_next.cnt = `PCS_CNT_W'(`PCS_HOLD_CYC - 1);
					core_next.st = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (core_reg.cnt != '0) begin
					core_next.cnt = core_reg.cnt - `PCS_CNT_W'(1);
				end else if (core_reg.split && !core_reg.hi) begin
					// Second byte of a word to an 8-bit I/O port
					core_next.hi = 1'b1;
					core_next.ca[0] = 1'b1;
					core_next.dout[`PCS_BYTE-1:0] = core_reg.req.wdata[`PCS_DW-1:`PCS_BYTE];
					core_next.cnt = `PCS_CNT_W'(`PCS_SETUP_CYC - 1);
					core_next.st = ST_SETUP;
				end else begin
					core_next.ce1_n = 1'b1;
					core_next.ce2_n = 1'b1;
					core_next.reg_n = 1'b1;
					core_next.dout_oe_n = 1'b1;
					core_next.rsp_valid = 1'b1;
					core_next.st = ST_IDLE;
				end
			end
			default: begin
				core_next.st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge I_CLK or negedge rst_n) begin
		if (!rst_n) begin
			core_reg <= '{st: ST_IDLE, s1: '1, s2: '1, dout_oe_n: 1'b1, reg_n: 1'b1, oe_n: 1'b1,
				we_n: 1'b1, iord_n: 1'b1, iowr_n: 1'b1, ce1_n: 1'b1, ce2_n: 1'b1,
				creset_oe_n: 1'b1, default: '0};
		end else begin
			core_reg <= core_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign O_RSP_VALID   = core_reg.rsp_valid;
	assign O_RSP_DATA    = core_reg.rdata;
	assign O_BUSY        = (core_reg.st != ST_IDLE) || fifo_valid;
	assign O_INPACK_SEEN = core_reg.inpack_seen;
	assign O_CA          = core_reg.ca;
	assign O_CD_OUT      = core_reg.dout;
	assign O_CD_OE_N     = core_reg.dout_oe_n;
	assign O_REG_N       = core_reg.reg_n;
	assign O_OE_N        = core_reg.oe_n;
	assign O_WE_N        = core_reg.we_n;
	assign O_IORD_N      = core_reg.iord_n;
	assign O_IOWR_N      = core_reg.iowr_n;
	assign O_CE1_N       = core_reg.ce1_n;
	assign O_CE2_N       = core_reg.ce2_n;
	assign O_CRESET      = core_reg.creset;
	assign O_CRESET_OE_N = core_reg.creset_oe_n;
endmodule : pcs_socket_strobes

//--- rtl/pcs_map.svh
// Constants for the PC Card socket strobe block
`ifndef PCS_MAP_SVH
`define PCS_MAP_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define PCS_AW          26
`define PCS_DW          16
`define PCS_BYTE        8
`define PCS_CNT_W       8
`define PCS_FIFO_DEPTH  16

// ----------------------------------------------------------------
// Timing, in ns, and derived cycle counts (least times round up)
// ----------------------------------------------------------------
`define PCS_CLK_MHZ     40
`define PCS_SETUP_NS    30
`define PCS_STROBE_NS   150
`define PCS_HOLD_NS     30
`define PCS_SETUP_CYC   ((`PCS_SETUP_NS * `PCS_CLK_MHZ + 999) / 1000)
`define PCS_STROBE_CYC  ((`PCS_STROBE_NS * `PCS_CLK_MHZ + 999) / 1000)
`define PCS_HOLD_CYC    ((`PCS_HOLD_NS * `PCS_CLK_MHZ + 999) / 1000)

// ----------------------------------------------------------------
// Positions in the synchronised pin vector
// ----------------------------------------------------------------
`define PCS_SY_WP       0
`define PCS_SY_INPACK   1
`define PCS_SY_RDY      2
`define PCS_SY_WAIT     3
`define PCS_SY_TC       4
`define PCS_SY_CD1      5
`define PCS_SY_CD2      6
`define PCS_SY_W        7

`endif

//--- rtl/pcs_pkg.sv
// Types shared by the PC Card socket strobe block
`include "pcs_map.svh"
package pcs_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD} pcs_state_type;

	typedef struct packed {
		logic                 write;
		logic                 io;
		logic                 attr;
		logic                 dma;
		logic                 wide;
		logic [`PCS_AW-1:0]   addr;
		logic [`PCS_DW-1:0]   wdata;
	} pcs_req_type;
endpackage : pcs_pkg

//--- rtl/pcs_fifo.sv
// Request FIFO with valid/ready on both sides
module pcs_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	// Fill side
	input  wire logic         i_in_valid,
	output logic              o_in_ready,
	input  wire logic [W-1:0] i_in_data,
	// Drain side
	output logic              o_out_valid,
	input  wire logic         i_out_ready,
	output logic [W-1:0]      o_out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wr;
		logic [AW-1:0]           rd;
		logic [AW:0]             cnt;
	} pcs_fifo_type;

	pcs_fifo_type fifo_reg;
	pcs_fifo_type fifo_next;
	logic         push;
	logic         pop;

	assign o_in_ready  = (fifo_reg.cnt != (AW+1)'(DEPTH));
	assign o_out_valid = (fifo_reg.cnt != '0);
	assign o_out_data  = fifo_reg.mem[fifo_reg.rd];
	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;

	always_comb begin
		fifo_next = fifo_reg;
		if (push) begin
			fifo_next.mem[fifo_reg.wr] = i_in_data;
			fifo_next.wr = (fifo_reg.wr == AW'(DEPTH-1)) ? '0 : fifo_reg.wr + AW'(1);
		end
		if (pop) begin
			fifo_next.rd = (fifo_reg.rd == AW'(DEPTH-1)) ? '0 : fifo_reg.rd + AW'(1);
		end
		fifo_next.cnt = fifo_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			fifo_reg <= '0;
		end else begin
			fifo_reg <= fifo_next;
		end
	end
endmodule : pcs_fifo

//--- verif/pcs_socket_properties.sv
// Concurrent checks on the socket pins of the strobe block
module pcs_socket_properties (
	// Clock, reset and configuration
	input wire logic I_CLK,
	input wire logic I_ARST_N,
	input wire logic I_ATA_MODE,
	input wire logic I_BUS8,
	input wire logic I_IF_ENABLE,
	input wire logic I_WAIT_N,
	// Socket pins and completion
	input wire logic O_REG_N,
	input wire logic O_OE_N,
	input wire logic O_WE_N,
	input wire logic O_IORD_N,
	input wire logic O_IOWR_N,
	input wire logic O_CE2_N,
	input wire logic O_CD_OE_N,
	input wire logic O_CRESET_OE_N,
	input wire logic O_RSP_VALID
);
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_ARST_N);
	// ----------------------------------------------------------------
	// Strobes
	// ----------------------------------------------------------------
	a_ata_reg_high: assert property ($past(I_ATA_MODE) && I_ATA_MODE |-> O_REG_N)
		else $error("REG low in ATA mode");
	a_one_strobe_only: assert property (!(!O_OE_N && !O_WE_N) && !(!O_IORD_N && !O_IOWR_N))
		else $error("two strobes of one kind low");
	a_iord_we_high: assert property (!O_IORD_N |-> O_WE_N)
		else $error("WE low during IORD");
	a_iowr_oe_high: assert property (!O_IOWR_N |-> O_OE_N)
		else $error("OE low during IOWR");
	a_iord_min_len: assert property ($fell(O_IORD_N) |-> !O_IORD_N [*6])
		else $error("IORD shorter than six cycles");
	a_iowr_min_len: assert property ($fell(O_IOWR_N) |-> !O_IOWR_N [*6])
		else $error("IOWR shorter than six cycles");
	a_wait_extends: assert property (!I_WAIT_N && !O_OE_N |=> !O_OE_N)
		else $error("OE ended while WAIT low");
	a_rsp_after_end: assert property (O_RSP_VALID |-> O_OE_N && O_WE_N && O_IORD_N && O_IOWR_N)
		else $error("completion while a strobe is low");
	a_bus8_no_ce2: assert property ($past(I_BUS8) && I_BUS8 |-> O_CE2_N)
		else $error("CE2 low on an 8-bit card");
	a_creset_float: assert property (!$past(I_IF_ENABLE) |-> O_CRESET_OE_N)
		else $error("card reset driven while disabled");
	a_no_drive_read: assert property (!O_CD_OE_N |-> O_OE_N && O_IORD_N)
		else $error("data driven during a read");
	c_iord: cover property ($fell(O_IORD_N));
	c_we: cover property ($fell(O_WE_N));
	c_rsp: cover property (O_RSP_VALID);
endmodule : pcs_socket_properties

//--- verif/pcs_card_model.sv
// Behavioural PC Card standing in the socket
module pcs_card_model (
	// Socket side
	input  wire logic        i_clk,
	input  wire logic [15:0] i_ca,
	input  wire logic [15:0] i_cd_out,
	input  wire logic        i_cd_oe_n,
	input  wire logic [3:0]  i_strobe_n,
	// Bench controls
	input  wire logic [7:0]  i_wait_len,
	input  wire logic        i_wp_n,
	input  wire logic        i_rdy_n,
	// Card pins
	output logic [15:0]      o_cd,
	output logic             o_inpack_n,
	output logic             o_wait_n,
	output logic             o_wp_n,
	output logic             o_rdy_n
);
	logic [15:0] last_reg = 16'h0000;
	logic [7:0]  cnt_reg  = 8'h00;
	always_ff @(posedge i_clk) begin
		// Remember only what was really on the bus
		if (!i_strobe_n[3] || !i_strobe_n[1] || !i_cd_oe_n)
			last_reg <= o_cd;
		cnt_reg  <= (&i_strobe_n) ? 8'h00 : cnt_reg + 8'h01;
	end
	always_comb begin
		if (!i_strobe_n[3] || !i_strobe_n[1])
			o_cd = ~i_ca;
		else if (!i_cd_oe_n)
			o_cd = i_cd_out;
		else
			o_cd = ~last_reg; // Released bus must not echo the last value
	end
	assign o_wait_n   = (&i_strobe_n) || (cnt_reg >= i_wait_len);
	// No card register decodes I/O offset 10h, so no acknowledge there
	assign o_inpack_n = i_strobe_n[1] || (i_ca[7:0] == 8'h10);
	assign o_wp_n     = i_wp_n;
	assign o_rdy_n    = i_rdy_n;
endmodule : pcs_card_model

//--- verif/tb_top.sv
// Self-checking bench for the socket strobe block
`include "pcs_map.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [4:0] MR = 5'h01, MRA = 5'h05, MW = 5'h11, IR = 5'h09, IW = 5'h19, DW = 5'h0b, DR = 5'h1b;
	logic I_CLK = 1'h0, I_ARST_N, I_REQ_VALID, I_REQ_WRITE, I_REQ_IO, I_REQ_ATTR, I_REQ_DMA, I_REQ_WIDE;
	logic I_IO_CARD, I_ATA_MODE, I_DMA_MODE, I_DREQ_SEL_INPACK, I_BUS8, I_IF_ENABLE, I_CARD_RESET;
	logic I_WP_IO16_N, I_INPACK_N, I_RDY_IREQ_N, I_WAIT_N, I_TC, O_REQ_READY, O_RSP_VALID, O_BUSY;
	logic O_WRITE_PROTECT, O_IO16, O_READY, O_CARD_IRQ, O_DMA_REQ, O_INPACK_SEEN, O_CARD_SEATED, O_CD_OE_N;
	logic O_REG_N, O_OE_N, O_WE_N, O_IORD_N, O_IOWR_N, O_CE1_N, O_CE2_N, O_CRESET, O_CRESET_OE_N;
	logic [1:0]         I_CDET_N;
	logic [`PCS_AW-1:0] I_REQ_ADDR, O_CA, m_ca;
	logic [`PCS_DW-1:0] I_REQ_WDATA, O_RSP_DATA, O_CD_OUT, I_CD_IN, m_wd;
	logic [7:0]         wait_len, acc, rsp_cnt, st;
	logic [3:0]         m_low;
	logic [2:0]         m_pin;
	logic               wp_n, rdy_n;
	int                 m_len, errors = 0, comparisons = 0;

	pcs_socket_strobes u_dut (.*);
	pcs_card_model u_card (.i_clk(I_CLK), .i_ca(O_CA[15:0]), .i_cd_out(O_CD_OUT), .i_cd_oe_n(O_CD_OE_N),
		.i_strobe_n({O_OE_N, O_WE_N, O_IORD_N, O_IOWR_N}), .i_wait_len(wait_len), .i_wp_n(wp_n),
		.i_rdy_n(rdy_n), .o_cd(I_CD_IN), .o_inpack_n(I_INPACK_N), .o_wait_n(I_WAIT_N),
		.o_wp_n(I_WP_IO16_N), .o_rdy_n(I_RDY_IREQ_N));

	always #12.5 I_CLK = ~I_CLK;
	// ----------------------------------------------------------------
	// Pin monitor: what the card saw during the strobes
	// ----------------------------------------------------------------
	always @(posedge I_CLK) begin
		#1;
		if (!(O_OE_N && O_WE_N && O_IORD_N && O_IOWR_N)) begin
			m_low |= ~{O_OE_N, O_WE_N, O_IORD_N, O_IOWR_N};
			m_pin = {O_REG_N, O_CE2_N, O_CE1_N};
			m_ca = O_CA;
			m_wd = O_CD_OUT;
			m_len++;
		end
		if (O_RSP_VALID === 1'h1)
			rsp_cnt++;
	end
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic op(input logic [4:0] k, input logic [25:0] a, input logic [15:0] d);
		logic [7:0] n;
		@(negedge I_CLK);
		{I_REQ_WRITE, I_REQ_IO, I_REQ_ATTR, I_REQ_DMA, I_REQ_WIDE} = k;
		I_REQ_ADDR = a;
		I_REQ_WDATA = d;
		I_REQ_VALID = 1'h1;
		m_low = 4'h0;
		m_len = 0;
		n = rsp_cnt;
		while (O_REQ_READY !== 1'h1) @(negedge I_CLK);
		@(negedge I_CLK);
		I_REQ_VALID = 1'h0;
		for (int i = 0; i < 400 && rsp_cnt == n; i++) @(negedge I_CLK);
		check(rsp_cnt != n, 1'h1);
	endtask : op
	task automatic complete_run();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : complete_run

	initial begin
		#400us;
		errors++;
		complete_run();
	end
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		{I_REQ_VALID, I_IO_CARD, I_ATA_MODE, I_DMA_MODE, I_DREQ_SEL_INPACK, I_BUS8, I_TC, I_CARD_RESET} = 8'h00;
		{I_REQ_WRITE, I_REQ_IO, I_REQ_ATTR, I_REQ_DMA, I_REQ_WIDE} = 5'h00;
		I_REQ_ADDR = 26'h0000000;
		I_REQ_WDATA = 16'h0000;
		I_IF_ENABLE = 1'h1;
		I_CDET_N = 2'h0;
		{wp_n, rdy_n, wait_len, rsp_cnt, I_ARST_N} = {2'h3, 16'h0000, 1'h0};
		repeat (8) @(negedge I_CLK);
		I_ARST_N = 1'h1;
		repeat (4) @(negedge I_CLK);
		op(MR, 26'h3fffffe, 16'h0000);
		check({m_low, m_pin}, 7'h44);
		check(m_ca, 26'h3fffffe);
		check(O_RSP_DATA, 16'h0001);
		op(MRA, 26'h0000a52, 16'h0000);
		check(m_pin[2], 1'h0);
		op(5'h00, 26'h0000a53, 16'h0000);
		check({m_pin, O_RSP_DATA}, {3'h5, 16'h00f5});
		op(MW, 26'h0001234, 16'hbeef);
		check({m_low, m_pin}, 7'h24);
		check(m_wd, 16'hbeef);
		op(5'h10, 26'h0000007, 16'h005a);
		check(m_pin, 3'h5);
		I_BUS8 = 1'h1;
		op(5'h10, 26'h0000007, 16'h005a);
		check({m_pin, m_ca[0]}, 4'hd);
		I_BUS8 = 1'h0;
		wait_len = 8'h14;
		op(MR, 26'h0000040, 16'h0000);
		check(m_len >= 20 && m_len <= 26, 1'h1);
		wait_len = 8'h00;
		$display("memory tests done");
		I_IO_CARD = 1'h1;
		wp_n = 1'h0;
		op(IR, 26'h0000300, 16'h0000);
		check({m_low, m_pin}, 7'h10);
		check({O_RSP_DATA, O_INPACK_SEEN, O_IO16}, {16'hfcff, 2'h3});
		op(IW, 26'h0000302, 16'h1357);
		check({m_low, m_pin}, 7'h08);
		wp_n = 1'h1;
		repeat (4) @(negedge I_CLK);
		op(IR, 26'h0000300, 16'h0000);
		check(O_RSP_DATA, 16'hfeff);
		check(m_ca, 26'h0000301);
		$display("io tests done");
		I_DMA_MODE = 1'h1;
		for (int t = 0; t < 4; t++) begin
			I_TC = t[0];
			op(t[1] ? DR : DW, 26'h0000000, 16'h2468);
			check({m_low, m_pin[2]}, {(t[1] ? {1'h0, t[0], 2'h1} : {t[0], 3'h2}), 1'h1});
		end
		I_TC = 1'h0;
		wp_n = 1'h0;
		repeat (4) @(negedge I_CLK);
		check(O_DMA_REQ, 1'h1);
		I_DREQ_SEL_INPACK = 1'h1;
		repeat (4) @(negedge I_CLK);
		check(O_DMA_REQ, 1'h0);
		{I_DMA_MODE, I_ATA_MODE} = 2'h1;
		op(IR, 26'h0000010, 16'h0000);
		check(m_pin[2], 1'h1);
		check(O_INPACK_SEEN, 1'h0);
		$display("dma and ata tests done");
		{I_ATA_MODE, rdy_n} = 2'h0;
		repeat (4) @(negedge I_CLK);
		check(O_CARD_IRQ, 1'h1);
		I_IO_CARD = 1'h0;
		repeat (4) @(negedge I_CLK);
		check({O_WRITE_PROTECT, O_READY}, 2'h0);
		{wp_n, rdy_n} = 2'h3;
		repeat (4) @(negedge I_CLK);
		check({O_WRITE_PROTECT, O_READY}, 2'h3);
		I_CDET_N = 2'h1;
		repeat (4) @(negedge I_CLK);
		check({O_CARD_SEATED, O_CRESET_OE_N}, 2'h1);
		{I_CDET_N, I_CARD_RESET} = 3'h1;
		repeat (4) @(negedge I_CLK);
		check({O_CARD_SEATED, O_CRESET_OE_N, O_CRESET}, 3'h5);
		I_IF_ENABLE = 1'h0;
		repeat (4) @(negedge I_CLK);
		check(O_CRESET_OE_N, 1'h1);
		I_IF_ENABLE = 1'h1;
		$display("status tests done");
		wait_len = 8'h1e;
		{I_REQ_WRITE, I_REQ_IO, I_REQ_ATTR, I_REQ_DMA, I_REQ_WIDE} = MW;
		st = rsp_cnt;
		acc = 8'h00;
		I_REQ_VALID = 1'h1;
		for (int i = 0; i < 40 && O_REQ_READY === 1'h1; i++) begin
			@(negedge I_CLK);
			acc++;
		end
		I_REQ_VALID = 1'h0;
		check(acc >= 16 && acc <= 17, 1'h1);
		for (int i = 0; i < 3000 && O_BUSY !== 1'h0; i++) @(negedge I_CLK);
		check({rsp_cnt - st, O_BUSY}, {acc, 1'h0});
		$display("fifo test done");
		complete_run();
	end
endmodule : tb_top

bind pcs_socket_strobes pcs_socket_properties u_props (.*);
